// file: design/cfd_decoder.sv
// cfd_decoder: custom card frame decoder with avalon-mm configuration registers.
// assumes one 100 MHz clk, a reader on the pins and an avalon-mm master.
`timescale 1ns/1ps
module cfd_decoder #(
    parameter int GAP_CYC = cfd_pkg::GAP_CYC
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic wg_d0_n,
    input wire logic wg_d1_n,
    input wire logic mag_clk_n,
    input wire logic mag_data_n,
    output logic [31:0] fac_code,
    output logic [31:0] card_num,
    output logic card_valid,
    output logic frame_error
);
    if (GAP_CYC < 2)
    begin : g_chk
        $error("cfd_decoder: GAP_CYC must be at least 2");
    end

    typedef struct packed {
        cfd_pkg::cfd_state_type st;
        logic wait_req;
        logic [31:0] rdata;
        logic [2:0] ctrl;
        logic [7:0] len;
        logic [15:0] fac_rng;
        logic [15:0] card_rng;
        logic [3:0][24:0] par;
        logic [31:0] setp;
        logic [31:0] clrp;
        logic [7:0] stat;
        logic [8:0] last_cnt;
        logic [8:0] cnt;
        logic [8:0] idx;
        logic [7:0] pos;
        logic pend;
        logic [31:0] fac_acc;
        logic [31:0] card_acc;
        logic [3:0] pacc;
        logic [3:0] pbit;
        logic set_err;
        logic clr_err;
        logic [31:0] fac_out;
        logic [31:0] card_out;
        logic valid;
        logic err;
    } cfd_main_type;

    cfd_main_type s;
    cfd_main_type n;
    cfd_bit_if bits();
    logic mem_we;
    logic mem_rdata;
    logic req;
    logic fac_in;
    logic card_in;
    logic len_err;
    logic frame_ok;
    logic [3:0] par_in;
    logic [3:0] par_at;
    logic [3:0] par_fail;
    logic [3:0] set_hit;
    logic [3:0] clr_hit;
    logic [31:0] wr_word;

    function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] wd,
                                              input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++)
        begin
            if (be[i])
            begin
                r[8*i +: 8] = wd[8*i +: 8];
            end
        end
        return r;
    endfunction : be_merge

    function automatic logic [31:0] rd_word(input cfd_main_type st, input logic [7:0] a);
        logic [31:0] r;
        r = 32'h0000_0000;
        case (a)
            cfd_pkg::OFS_CTRL: r = {29'h0, st.ctrl};
            cfd_pkg::OFS_LEN: r = {24'h0, st.len};
            cfd_pkg::OFS_FAC: r = {16'h0, st.fac_rng};
            cfd_pkg::OFS_CARD: r = {16'h0, st.card_rng};
            cfd_pkg::OFS_SET: r = st.setp;
            cfd_pkg::OFS_CLR: r = st.clrp;
            cfd_pkg::OFS_STAT: r = {24'h0, st.stat};
            cfd_pkg::OFS_CNT: r = {23'h0, st.last_cnt};
            cfd_pkg::OFS_FACV: r = st.fac_out;
            cfd_pkg::OFS_CARDV: r = st.card_out;
            default: r = 32'h0000_0000;
        endcase
        for (int k = 0; k < cfd_pkg::NUM_BLK; k++)
        begin
            if (a == cfd_pkg::OFS_PAR0 + 8'(4 * k))
            begin
                r = {7'h0, st.par[k]};
            end
        end
        return r;
    endfunction : rd_word

    cfd_rx #(
        .GAP_CYC(GAP_CYC)
    ) u_rx (
        .clk(clk),
        .rst(rst),
        .mag_mode(s.ctrl[cfd_pkg::CTRL_MAG_BIT]),
        .wg_d0_n(wg_d0_n),
        .wg_d1_n(wg_d1_n),
        .mag_clk_n(mag_clk_n),
        .mag_data_n(mag_data_n),
        .link(bits)
    );

    cfd_frame_mem #(
        .AW(8)
    ) u_mem (
        .clk(clk),
        .we(mem_we),
        .waddr(s.cnt[7:0]),
        .wdata(bits.val),
        .raddr(s.idx[7:0]),
        .rdata(mem_rdata)
    );

    // bits past 256 are dropped; such a frame fails the count check anyway
    assign mem_we = (s.st == cfd_pkg::ST_RX) && bits.stb && s.ctrl[cfd_pkg::CTRL_EN_BIT]
                    && (s.cnt != 9'h100);
    assign req = avs_read | avs_write;
    // lane merge against the current contents, shared by every writable register except the status clear
    assign wr_word = be_merge(rd_word(s, avs_address), avs_writedata, avs_byteenable);
    assign fac_in = (s.pos >= s.fac_rng[cfd_pkg::RNG_START_LSB +: 8])
                    && (s.pos <= s.fac_rng[cfd_pkg::RNG_END_LSB +: 8]);
    assign card_in = (s.pos >= s.card_rng[cfd_pkg::RNG_START_LSB +: 8])
                     && (s.pos <= s.card_rng[cfd_pkg::RNG_END_LSB +: 8]);
    assign len_err = s.cnt != {1'b0, s.len};
    assign frame_ok = !len_err && (par_fail == 4'h0) && !s.set_err && !s.clr_err;

    for (genvar g = 0; g < cfd_pkg::NUM_BLK; g++)
    begin : g_blk
        logic [7:0] loc;
        logic [7:0] pst;
        logic [7:0] pen;
        assign loc = s.par[g][cfd_pkg::PAR_LOC_LSB +: 8];
        assign pst = s.par[g][cfd_pkg::PAR_START_LSB +: 8];
        assign pen = s.par[g][cfd_pkg::PAR_END_LSB +: 8];
        assign par_in[g] = (s.pos >= pst) && (s.pos <= pen);
        assign par_at[g] = s.pos == loc;
        // even: block plus parity bit holds an even count of ones
        assign par_fail[g] = (loc != cfd_pkg::POS_NONE) && (pst != cfd_pkg::POS_NONE)
                             && (pen != cfd_pkg::POS_NONE)
                             && ((s.pacc[g] ^ s.pbit[g]) != s.par[g][cfd_pkg::PAR_ODD_BIT]);
        assign set_hit[g] = (s.setp[8*g +: 8] != cfd_pkg::POS_NONE)
                            && (s.pos == s.setp[8*g +: 8]);
        assign clr_hit[g] = (s.clrp[8*g +: 8] != cfd_pkg::POS_NONE)
                            && (s.pos == s.clrp[8*g +: 8]);
    end

    always_comb
    begin
        n = s;
        n.valid = 1'b0;
        n.err = 1'b0;
        n.wait_req = ~(req & s.wait_req);
        if (req && s.wait_req)
        begin
            n.rdata = rd_word(s, avs_address);
        end
        // one register set, shared by every frame whatever the line type
        if (avs_write && !s.wait_req)
        begin
            case (avs_address)
                cfd_pkg::OFS_CTRL:
                    n.ctrl = wr_word[2:0];
                cfd_pkg::OFS_LEN:
                    n.len = wr_word[7:0];
                cfd_pkg::OFS_FAC:
                    n.fac_rng = wr_word[15:0];
                cfd_pkg::OFS_CARD:
                    n.card_rng = wr_word[15:0];
                cfd_pkg::OFS_SET:
                    n.setp = wr_word;
                cfd_pkg::OFS_CLR:
                    n.clrp = wr_word;
                cfd_pkg::OFS_STAT:
                    n.stat = s.stat & ~(avs_writedata[7:0] & {8{avs_byteenable[0]}});
                default:
                    n.ctrl = s.ctrl;
            endcase
            for (int k = 0; k < cfd_pkg::NUM_BLK; k++)
            begin
                if (avs_address == cfd_pkg::OFS_PAR0 + 8'(4 * k))
                begin
                    n.par[k] = wr_word[24:0];
                end
            end
        end
        unique case (s.st)
            cfd_pkg::ST_RX:
            begin
                // frames arriving before software enables the layout are ignored
                if (mem_we)
                begin
                    n.cnt = s.cnt + 9'h001;
                end
                if (bits.fend && (s.cnt != 9'h000))
                begin
                    n.st = cfd_pkg::ST_WALK;
                    n.idx = 9'h000;
                    n.pend = 1'b0;
                    n.fac_acc = 32'h0000_0000;
                    n.card_acc = 32'h0000_0000;
                    n.pacc = 4'h0;
                    n.pbit = 4'h0;
                    n.set_err = 1'b0;
                    n.clr_err = 1'b0;
                end
            end
            cfd_pkg::ST_WALK:
            begin
                if (s.pend)
                begin
                    if (fac_in)
                    begin
                        n.fac_acc = {s.fac_acc[30:0], mem_rdata};
                    end
                    if (card_in)
                    begin
                        n.card_acc = {s.card_acc[30:0], mem_rdata};
                    end
                    for (int k = 0; k < cfd_pkg::NUM_BLK; k++)
                    begin
                        if (par_in[k])
                        begin
                            n.pacc[k] = s.pacc[k] ^ mem_rdata;
                        end
                        if (par_at[k])
                        begin
                            n.pbit[k] = mem_rdata;
                        end
                    end
                    // a position beyond the frame end is never checked
                    if ((set_hit != 4'h0) && !mem_rdata)
                    begin
                        n.set_err = 1'b1;
                    end
                    if ((clr_hit != 4'h0) && mem_rdata)
                    begin
                        n.clr_err = 1'b1;
                    end
                end
                if (s.idx < s.cnt)
                begin
                    n.pos = s.idx[7:0];
                    n.idx = s.idx + 9'h001;
                    n.pend = 1'b1;
                end
                else
                begin
                    n.pend = 1'b0;
                    n.st = cfd_pkg::ST_DONE;
                end
            end
            cfd_pkg::ST_DONE:
            begin
                // set after the bus clear above, so a new event beats a clear
                n.stat = n.stat | {par_fail, frame_ok, s.clr_err, s.set_err, len_err};
                n.last_cnt = s.cnt;
                n.cnt = 9'h000;
                n.st = cfd_pkg::ST_RX;
                if (frame_ok)
                begin
                    n.valid = 1'b1;
                    if (s.ctrl[cfd_pkg::CTRL_W32_BIT])
                    begin
                        n.fac_out = s.fac_acc;
                        n.card_out = s.card_acc;
                    end
                    else
                    begin
                        n.fac_out = {16'h0000, s.fac_acc[15:0]};
                        n.card_out = {16'h0000, s.card_acc[15:0]};
                    end
                end
                else
                begin
                    n.err = 1'b1;
                end
            end
        endcase
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            s <= '{st: cfd_pkg::ST_RX, wait_req: 1'b1, ctrl: cfd_pkg::RST_CTRL,
                   len: cfd_pkg::RST_LEN, fac_rng: cfd_pkg::RST_FAC,
                   card_rng: cfd_pkg::RST_CARD, par: {4{cfd_pkg::RST_PAR}},
                   setp: cfd_pkg::RST_POS, clrp: cfd_pkg::RST_POS, default: '0};
        end
        else
        begin
            s <= n;
        end
    end

    assign avs_readdata = s.rdata;
    assign avs_waitrequest = s.wait_req;
    assign fac_code = s.fac_out;
    assign card_num = s.card_out;
    assign card_valid = s.valid;
    assign frame_error = s.err;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    property p_valid_pulse;
        card_valid |=> !card_valid;
    endproperty
    a_valid_pulse: assert property (p_valid_pulse) else $error("valid longer than one cycle");

    property p_ok_err_excl;
        !(card_valid && frame_error);
    endproperty
    a_ok_err_excl: assert property (p_ok_err_excl) else $error("valid and error together");

    property p_len_err;
        (s.st == cfd_pkg::ST_DONE) && len_err |=> frame_error && s.stat[cfd_pkg::ST_LEN_BIT];
    endproperty
    a_len_err: assert property (p_len_err) else $error("count mismatch not flagged");

    property p_width16;
        card_valid && !s.ctrl[cfd_pkg::CTRL_W32_BIT] |-> (fac_code[31:16] == 16'h0000)
            && (card_num[31:16] == 16'h0000);
    endproperty
    a_width16: assert property (p_width16) else $error("16-bit result has upper bits");

    property p_par_err;
        (s.st == cfd_pkg::ST_DONE) && (par_fail != 4'h0) |=> frame_error && !card_valid;
    endproperty
    a_par_err: assert property (p_par_err) else $error("parity failure not flagged");

    property p_set_err;
        (s.st == cfd_pkg::ST_DONE) && s.set_err |=> frame_error ##0 s.stat[cfd_pkg::ST_SET_BIT];
    endproperty
    a_set_err: assert property (p_set_err) else $error("set bit failure not flagged");

    property p_clr_err;
        (s.st == cfd_pkg::ST_DONE) && s.clr_err |=> frame_error ##0 s.stat[cfd_pkg::ST_CLR_BIT];
    endproperty
    a_clr_err: assert property (p_clr_err) else $error("clear bit failure not flagged");

    property p_disabled;
        (s.st == cfd_pkg::ST_RX) && !s.ctrl[cfd_pkg::CTRL_EN_BIT] && (s.cnt == 9'h000)
            |=> (s.cnt == 9'h000);
    endproperty
    a_disabled: assert property (p_disabled) else $error("bits taken while disabled");

    property p_walk_end;
        $rose(s.st == cfd_pkg::ST_WALK) |-> ##[1:258] (s.st == cfd_pkg::ST_DONE);
    endproperty
    a_walk_end: assert property (p_walk_end) else $error("frame check did not finish");

    property p_bus_ans;
        req && avs_waitrequest |=> !avs_waitrequest ##1 avs_waitrequest;
    endproperty
    a_bus_ans: assert property (p_bus_ans) else $error("bus answer not one cycle late");

    c_valid: cover property (card_valid);
    c_error: cover property (frame_error);
    c_mag_valid: cover property (card_valid && s.ctrl[cfd_pkg::CTRL_MAG_BIT]);
    c_par_ok: cover property (card_valid && (s.par[0][7:0] != cfd_pkg::POS_NONE));
endmodule : cfd_decoder

// file: design/cfd_pkg.sv
// cfd_pkg: register map, field layout, reset values and state codes of the card frame decoder.
// assumes a 100 MHz clk and 32-bit avalon-mm registers, one word each.
// Operation
// - frames arrive over wiegand data lines or a magnetic clock and data pair
// - expected bit count 0..255 is held and compared with every frame
// - facility code is taken from a start to an end bit index, defaults 1 and 8
// - card number is taken from a start to an end bit index, defaults 9 and 24
// - results are delivered 16 or 32 bits wide, 32 is the safe choice
// - four independent parity blocks are checked over each frame
// - each block has a parity bit position, 255 disables the block
// - each block has a start index of its covered bits, 255 disables it
// - each block has an end index of its covered bits, 255 disables it
// - each block is checked as even or odd parity
// - four positions must read one, 255 disables a position
// - four positions must read zero, 255 disables a position
// - one layout exists and is shared by every frame decoded
package cfd_pkg;
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_LEN = 8'h04;
    localparam logic [7:0] OFS_FAC = 8'h08;
    localparam logic [7:0] OFS_CARD = 8'h0C;
    localparam logic [7:0] OFS_PAR0 = 8'h10;
    localparam logic [7:0] OFS_SET = 8'h20;
    localparam logic [7:0] OFS_CLR = 8'h24;
    localparam logic [7:0] OFS_STAT = 8'h28;
    localparam logic [7:0] OFS_CNT = 8'h2C;
    localparam logic [7:0] OFS_FACV = 8'h30;
    localparam logic [7:0] OFS_CARDV = 8'h34;
    localparam int CTRL_MAG_BIT = 0;
    localparam int CTRL_W32_BIT = 1;
    localparam int CTRL_EN_BIT = 2;
    localparam logic [2:0] RST_CTRL = 3'h2;
    localparam logic [7:0] RST_LEN = 8'h1A;
    localparam logic [15:0] RST_FAC = 16'h0801;
    localparam logic [15:0] RST_CARD = 16'h1809;
    localparam int RNG_START_LSB = 0;
    localparam int RNG_END_LSB = 8;
    localparam int PAR_LOC_LSB = 0;
    localparam int PAR_START_LSB = 8;
    localparam int PAR_END_LSB = 16;
    localparam int PAR_ODD_BIT = 24;
    localparam logic [24:0] RST_PAR = 25'h0FFFFFF;
    localparam logic [31:0] RST_POS = 32'hFFFF_FFFF;
    localparam logic [7:0] POS_NONE = 8'hFF;
    localparam int ST_LEN_BIT = 0;
    localparam int ST_SET_BIT = 1;
    localparam int ST_CLR_BIT = 2;
    localparam int ST_OK_BIT = 3;
    localparam int ST_PAR_LSB = 4;
    localparam int NUM_BLK = 4;
    localparam int CLK_MHZ = 100;
    localparam int GAP_US = 2000;
    localparam int GAP_CYC = GAP_US * CLK_MHZ;
    typedef enum logic [2:0] {
        ST_RX = 3'b001,
        ST_WALK = 3'b010,
        ST_DONE = 3'b100
    } cfd_state_type;
endpackage : cfd_pkg

// file: design/cfd_bit_if.sv
// cfd_bit_if: received bit strobe and end of frame from the line receiver.
// assumes both ends on the same clk.
`timescale 1ns/1ps
interface cfd_bit_if;
    logic stb;
    logic val;
    logic fend;
    modport src (output stb, output val, output fend);
    modport dst (input stb, input val, input fend);
endinterface : cfd_bit_if

// file: design/cfd_frame_mem.sv
// cfd_frame_mem: one bit per received frame position, registered read.
// assumes writes and reads on the same clk.
`timescale 1ns/1ps
module cfd_frame_mem #(
    parameter int AW = 8
) (
    input wire logic clk,
    input wire logic we,
    input wire logic [AW-1:0] waddr,
    input wire logic wdata,
    input wire logic [AW-1:0] raddr,
    output logic rdata
);
    logic mem [0:(1<<AW)-1];

    always_ff @(posedge clk)
    begin
        if (we)
        begin
            mem[waddr] <= wdata;
        end
        rdata <= mem[raddr];
    end
endmodule : cfd_frame_mem

// file: design/cfd_rx.sv
// cfd_rx: line receiver, wiegand or magnetic, with inter-bit gap frame end.
// assumes idle-high active-low pins from outside the clk domain.
`timescale 1ns/1ps
module cfd_rx #(
    parameter int GAP_CYC = cfd_pkg::GAP_CYC
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic mag_mode,
    input wire logic wg_d0_n,
    input wire logic wg_d1_n,
    input wire logic mag_clk_n,
    input wire logic mag_data_n,
    cfd_bit_if.src link
);
    localparam int GW = $clog2(GAP_CYC + 1);
    typedef struct packed {
        logic [3:0] s1;
        logic [3:0] s2;
        logic [3:0] prev;
        logic [GW-1:0] gap;
        logic seen;
        logic stb;
        logic val;
        logic fend;
    } cfd_rx_type;
    cfd_rx_type s;
    cfd_rx_type n;
    logic [3:0] fall;

    assign fall = s.prev & ~s.s2;
    assign link.stb = s.stb;
    assign link.val = s.val;
    assign link.fend = s.fend;

    always_comb
    begin
        n = s;
        n.s1 = {mag_data_n, mag_clk_n, wg_d1_n, wg_d0_n};
        n.s2 = s.s1;
        n.prev = s.s2;
        n.stb = 1'b0;
        n.fend = 1'b0;
        // both wiegand lines falling together is a glitch, not a bit
        if (!mag_mode && (fall[0] ^ fall[1]))
        begin
            n.stb = 1'b1;
            n.val = fall[1];
        end
        if (mag_mode && fall[2])
        begin
            n.stb = 1'b1;
            n.val = ~s.s2[3];
        end
        if (n.stb)
        begin
            n.gap = '0;
            n.seen = 1'b1;
        end
        else if (s.seen)
        begin
            if (s.gap == GW'(GAP_CYC - 1))
            begin
                n.fend = 1'b1;
                n.seen = 1'b0;
                n.gap = '0;
            end
            else
            begin
                n.gap = s.gap + GW'(1);
            end
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            s <= '{s1: 4'hF, s2: 4'hF, prev: 4'hF, default: '0};
        end
        else
        begin
            s <= n;
        end
    end
endmodule : cfd_rx

// file: tb/cfd_rdr_model.sv
// cfd_rdr_model: card reader model driving the wiegand or magnetic pins.
// assumes send is called right after a rising clk edge.
`timescale 1ns/1ps
module cfd_rdr_model (
    input wire logic clk,
    output logic wg_d0_n,
    output logic wg_d1_n,
    output logic mag_clk_n,
    output logic mag_data_n
);
    // lines idle high; the magnetic clock stands still between frames
    initial
    begin
        wg_d0_n = 1'b1;
        wg_d1_n = 1'b1;
        mag_clk_n = 1'b1;
        mag_data_n = 1'b1;
    end
    // 8 clk per wiegand bit and 9 per magnetic bit keep the edge spacing well above the 4 clk minimum
    task automatic send(input logic [255:0] f, input int n, input logic mag);
        for (int i = 0; i < n; i++)
        begin
            if (mag)
            begin
                mag_data_n <= ~f[i];
                @(posedge clk);
                mag_clk_n <= 1'b0;
            end
            else if (f[i])
                wg_d1_n <= 1'b0;
            else
                wg_d0_n <= 1'b0;
            repeat (4) @(posedge clk);
            wg_d0_n <= 1'b1;
            wg_d1_n <= 1'b1;
            mag_clk_n <= 1'b1;
            mag_data_n <= 1'b1; // released data returns to its pull-up level
            repeat (4) @(posedge clk);
        end
    endtask : send
endmodule : cfd_rdr_model

// file: tb/testbench.sv
// testbench: self-checking bench of the card frame decoder.
// assumes GAP_CYC of 50 so a frame end takes microseconds, not milliseconds.
`timescale 1ns/1ps
module testbench;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] avs_address = 8'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic wg_d0_n, wg_d1_n, mag_clk_n, mag_data_n;
    logic [31:0] fac_code, card_num, q;
    logic card_valid, frame_error;
    logic [255:0] fr;
    int error_cnt = 0;
    int tests_run = 0;
    cfd_decoder #(.GAP_CYC(50)) cfd_decoder_i (.clk(clk), .rst(rst),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .wg_d0_n(wg_d0_n), .wg_d1_n(wg_d1_n), .mag_clk_n(mag_clk_n),
        .mag_data_n(mag_data_n), .fac_code(fac_code), .card_num(card_num),
        .card_valid(card_valid), .frame_error(frame_error));
    cfd_rdr_model cfd_rdr_model_i (.clk(clk), .wg_d0_n(wg_d0_n), .wg_d1_n(wg_d1_n),
        .mag_clk_n(mag_clk_n), .mag_data_n(mag_data_n));
    initial
    begin
        forever #5 clk = ~clk;
    end
    task automatic complete_run;
        $display("tests %0d errors %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : complete_run
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        tests_run++;
        if (g !== e)
        begin
            error_cnt++;
            $display("BAD %0t got %h expected %h", $time, g, e);
        end
    endtask : chk
    // one access; held until waitrequest is sampled low, released a cycle apart
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        avs_address <= a;
        avs_write <= w;
        avs_read <= ~w;
        avs_writedata <= d;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (avs_waitrequest !== 1'b0 && n < 100);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        if (n >= 100)
        begin
            chk(32'h0, 32'h1);
            complete_run();
        end
        @(posedge clk);
    endtask : bus
    // first-received bit is the msb; parity 0 even over 1..12, parity 1 odd over 13..24
    function automatic logic [255:0] mk(input logic [7:0] fc, input logic [15:0] cn);
        logic [255:0] f;
        f = '0;
        for (int k = 0; k < 8; k++)
            f[1+k] = fc[7-k];
        for (int k = 0; k < 16; k++)
            f[9+k] = cn[15-k];
        f[0] = ^f[12:1];
        f[25] = ~^f[24:13];
        return f;
    endfunction : mk
    // k: 0 nothing, 1 good frame, 2 rejected frame
    task automatic wres(input int k, input logic [31:0] f, input logic [31:0] c);
        int n;
        n = 0;
        while (card_valid !== 1'b1 && frame_error !== 1'b1 && n < 200)
        begin
            @(negedge clk);
            n++;
        end
        chk({31'h0, card_valid}, {31'h0, k == 1});
        chk({31'h0, frame_error}, {31'h0, k == 2});
        if (k == 1)
        begin
            chk(fac_code, f);
            chk(card_num, c);
        end
        @(posedge clk);
        if (k != 0 && n >= 200)
            complete_run();
    endtask : wres
    task automatic t_reset;
        bus(1'b0, cfd_pkg::OFS_CTRL, 32'h0);
        chk(q, 32'h2);
        bus(1'b0, cfd_pkg::OFS_LEN, 32'h0);
        chk(q, 32'h1A);
        bus(1'b0, cfd_pkg::OFS_FAC, 32'h0);
        chk(q, 32'h0801);
        bus(1'b0, cfd_pkg::OFS_CARD, 32'h0);
        chk(q, 32'h1809);
        bus(1'b0, 8'h40, 32'h0);
        chk(q, 32'h0);
    endtask : t_reset
    task automatic t_cfg;
        bus(1'b1, cfd_pkg::OFS_PAR0, 32'h000C0100);
        bus(1'b1, 8'h14, 32'h01180D19);
        bus(1'b1, cfd_pkg::OFS_SET, 32'hFFFFFF01);
        bus(1'b1, cfd_pkg::OFS_CLR, 32'hFFFFFF02);
        cfd_rdr_model_i.send(mk(8'hA5, 16'h1234), 26, 1'b0);
        wres(0, 32'h0, 32'h0);
        bus(1'b1, cfd_pkg::OFS_CTRL, 32'h6);
    endtask : t_cfg
    task automatic t_good;
        cfd_rdr_model_i.send(mk(8'hA5, 16'h1234), 26, 1'b0);
        wres(1, 32'hA5, 32'h1234);
        bus(1'b0, cfd_pkg::OFS_STAT, 32'h0);
        chk(q, 32'h08);
        bus(1'b0, cfd_pkg::OFS_CNT, 32'h0);
        chk(q, 32'h1A);
        bus(1'b0, cfd_pkg::OFS_FACV, 32'h0);
        chk(q, 32'hA5);
        cfd_rdr_model_i.send(mk(8'hA5, 16'hBEEF), 26, 1'b0);
        wres(1, 32'hA5, 32'hBEEF);
    endtask : t_good
    // parity 0, parity 1, set bit, clear bit, short frame
    task automatic t_bad;
        for (int i = 0; i < 5; i++)
        begin
            fr = mk(i == 2 ? 8'h25 : i == 3 ? 8'hE5 : 8'hA5, 16'h0F0F);
            fr[0] = fr[0] ^ (i == 0);
            fr[25] = fr[25] ^ (i == 1);
            cfd_rdr_model_i.send(fr, i == 4 ? 25 : 26, 1'b0);
            wres(2, 32'h0, 32'h0);
        end
        bus(1'b0, cfd_pkg::OFS_STAT, 32'h0);
        chk(q & 32'h0000_000F, 32'h0000_000F);
        bus(1'b1, cfd_pkg::OFS_STAT, 32'hFF);
        bus(1'b0, cfd_pkg::OFS_STAT, 32'h0);
        chk(q, 32'h0);
    endtask : t_bad
    task automatic t_mag;
        bus(1'b1, cfd_pkg::OFS_CTRL, 32'h5);
        bus(1'b1, cfd_pkg::OFS_CARD, 32'h1801);
        bus(1'b1, cfd_pkg::OFS_PAR0, 32'h000C01FF);
        fr = mk(8'hA5, 16'h3C3C);
        fr[0] = ~fr[0];
        cfd_rdr_model_i.send(fr, 26, 1'b1);
        wres(1, 32'hA5, 32'h3C3C);
    endtask : t_mag
    initial
    begin
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        t_reset();
        t_cfg();
        t_good();
        t_bad();
        t_mag();
        complete_run();
    end
endmodule : testbench
